// File: rtl/pll_clk_pkg.sv
// Purpose: Shared constants for the audio PLL and clock divider configuration block
// Assumes: 8-bit control registers on page 0, core clock of 125 MHz
// Notes:   Offsets are byte addresses of the control port register space
package pll_clk_pkg;

	// Register offsets
	localparam logic [7:0] PLL_ON_OFF    = 8'h04; // PLL on/off control
	localparam logic [7:0] REF_SEL_OFF   = 8'h0d; // PLL reference select
	localparam logic [7:0] P_OFF         = 8'h14; // Pre-divider P
	localparam logic [7:0] J_OFF         = 8'h15; // Integer multiplier J
	localparam logic [7:0] D_HIGH_OFF    = 8'h16; // Fraction D, upper bits
	localparam logic [7:0] D_LOW_OFF     = 8'h17; // Fraction D, lower byte
	localparam logic [7:0] R_OFF         = 8'h18; // Post multiplier R
	localparam logic [7:0] PROC_DIV_OFF  = 8'h1b; // Processing clock divider
	localparam logic [7:0] BIT_DIV_OFF   = 8'h20; // Bit clock out divider
	localparam logic [7:0] FRAME_DIV_OFF = 8'h21; // Frame clock out divider

	// Field positions and widths
	localparam int REF_LSB  = 4;  // Reference select sits in bits 6:4
	localparam int REF_W    = 3;
	localparam int P_W      = 4;
	localparam int J_W      = 6;
	localparam int D_HIGH_W = 6;
	localparam int D_W      = 14; // Upper 6 bits plus lower 8 bits
	localparam int R_W      = 4;
	localparam int PROC_W   = 7;
	localparam int BIT_W    = 7;
	localparam int FRAME_W  = 8;

	// Values after reset
	localparam logic              PLL_ON_RST = 1'b1;
	localparam logic [REF_W-1:0]  REF_RST    = 3'h0;
	localparam logic [P_W-1:0]    P_RST      = 4'h0;
	localparam logic [J_W-1:0]    J_RST      = 6'h08;
	localparam logic [D_W-1:0]    D_RST      = 14'h0000;
	localparam logic [R_W-1:0]    R_RST      = 4'h0;
	localparam logic [7:0]        DIV_RST    = 8'h00;

	// Reference source codes
	localparam logic [REF_W-1:0] REF_MASTER = 3'h0;
	localparam logic [REF_W-1:0] REF_BIT    = 3'h1;
	localparam logic [REF_W-1:0] REF_GPIO   = 3'h3;

	// Coefficient limits
	localparam int J_MIN      = 4;
	localparam int J_FRAC_MAX = 11;
	localparam int D_MAX      = 9999;
	localparam int DEC_SCALE  = 10000; // Four decimal digits of fraction

	// Sample rate ratio N, field holds N minus one
	localparam int          SAMPLE_N_W   = 11;
	localparam int          SAMPLE_N     = 2048;
	localparam logic [10:0] SAMPLE_RATIO = 11'(SAMPLE_N - 1);

	// Master clock to frame ratios
	localparam logic [11:0] RATIO_64  = 12'h040;
	localparam logic [11:0] RATIO_128 = 12'h080;
	localparam logic [11:0] RATIO_192 = 12'h0c0;
	localparam logic [11:0] RATIO_256 = 12'h100;
	localparam logic [11:0] RATIO_384 = 12'h180;
	localparam logic [11:0] RATIO_512 = 12'h200;

	// Timing
	localparam int CLK_HZ      = 125_000_000;
	localparam int FS_SPLIT_HZ = 64_000; // Between 48 kHz and 88.2 kHz
	localparam int FS_SPLIT_CYC = CLK_HZ / FS_SPLIT_HZ;
	localparam int READY_MS    = 4;
	localparam int READY_CYC   = READY_MS * (CLK_HZ / 1000);
	localparam int ACT_CYC     = 32768; // Longest gap between edges of a live clock

endpackage : pll_clk_pkg

// File: rtl/div_if.sv
// Purpose: Carrier between the configuration block and one clock divider
// Assumes: Ticks are one-cycle pulses in the core clock domain
// Notes:   Ratio holds the divide ratio minus one
`timescale 1ns/10ps
interface div_if #(
	parameter int W = 8
);
	logic         tick_in;   // Source edge pulse
	logic [W-1:0] ratio;     // Divide ratio minus one
	logic         tick_out;  // Divided edge pulse
	logic         level_out; // Divided square level

	modport div (input tick_in, input ratio, output tick_out, output level_out);
	modport ctl (output tick_in, output ratio, input tick_out, input level_out);
endinterface : div_if

// File: rtl/clk_div.sv
// Purpose: Programmable divider of a tick stream
// Assumes: Source ticks are single-cycle pulses
// Notes:   A ratio field of zero passes every tick through
`timescale 1ns/10ps
module clk_div #(
	parameter int W = 8
) (
	input  wire logic clk,
	input  wire logic rst_b,
	div_if.div        d
);
	initial begin
		if (W < 1 || W > 16) begin
			$error("clk_div: W must lie in 1..16");
		end
	end

	logic [W-1:0] cnt_reg;  // Source ticks seen in this period
	logic [W-1:0] cnt_next;
	logic         wrap;     // Last tick of a period

	// Wrap once the count reaches ratio, so field value n divides by n+1
	always_comb begin
		wrap     = d.tick_in && (cnt_reg >= d.ratio);
		cnt_next = cnt_reg;
		if (wrap) begin
			cnt_next = '0;
		end else if (d.tick_in) begin
			cnt_next = cnt_reg + W'(1);
		end
	end

	// Counter
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// Output pulse and level; a divide by one holds the level high
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			d.tick_out  <= 1'b0;
			d.level_out <= 1'b0;
		end else begin
			d.tick_out  <= wrap;
			d.level_out <= (cnt_next <= (d.ratio >> 1));
		end
	end

endmodule : clk_div

// File: rtl/audio_pll_clock_generation.sv
// Purpose: PLL reference, coefficient and divider configuration for an audio amplifier
// Assumes: Clock pins arrive sampled synchronously to clk; an analog PLL macro
//          consumes the coefficient outputs and returns its output on pll_output_clock
// Notes:   Register writes are held off until the incoming clocks have run
//
// Notes on behaviour
// - Reference picks bit, master or GPIO clock.
// - Clearing the on bit bypasses to master clock.
// - PLL on bit resets to one.
// - Output equals input times R times J.D over P.
// - R 1..16, J 4..63, D 0..9999.
// - J integer part, D four fraction digits.
// - Sample rate is PLL output over 2048.
// - P, J, D, R fields at fixed registers.
// - Processing, bit and frame dividers programmable.
// - 128 and 192 ratios need the PLL.
// - Ratio 64 is never supported.
// - Divider fields hold ratio minus one.
// - Writes accepted only after 4 ms clocking.
`timescale 1ns/10ps
module audio_pll_clock_generation
	import pll_clk_pkg::*;
#(
	parameter int READY_CYCLES = pll_clk_pkg::READY_CYC, // Clock run-in before writes
	parameter int ACT_CYCLES   = pll_clk_pkg::ACT_CYC    // Gap that marks a clock dead
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        master_clk_in,
	input  wire logic        bit_clk_in,
	input  wire logic        frame_sync_clock,
	input  wire logic        gpio_clk_in,
	input  wire logic        pll_output_clock,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             reg_ready,
	output logic             pll_on_bit,
	output logic             pll_input_clock,
	output logic      [4:0]  pll_pre_div,
	output logic      [23:0] pll_mult,
	output logic             pll_cfg_error,
	output logic             proc_clk_tick,
	output logic             proc_clk,
	output logic             bit_clk_out,
	output logic             frame_clk_out,
	output logic             sample_tick,
	output logic      [11:0] mclk_ratio,
	output logic             clk_ratio_error
);
	import pll_clk_pkg::*;

	initial begin
		if (READY_CYCLES < 1 || ACT_CYCLES < 2) begin
			$error("audio_pll_clock_generation: run-in counts too small");
		end
	end

	// Register storage
	logic [REF_W-1:0]   pll_ref_source_field_reg; // Reference source select
	logic [P_W-1:0]     pll_p_field_reg;          // P minus one
	logic [J_W-1:0]     pll_j_field_reg;          // J, integer part
	logic [D_W-1:0]     pll_d_field_reg;          // D, fraction digits
	logic [R_W-1:0]     pll_r_field_reg;          // R minus one
	logic [PROC_W-1:0]  processing_clock_div_reg; // Ratio minus one
	logic [BIT_W-1:0]   bit_clock_out_div_reg;    // Ratio minus one
	logic [FRAME_W-1:0] frame_clock_out_div_reg;  // Ratio minus one

	// Sampled pin history for edge detection
	logic mclk_d_reg;
	logic bclk_d_reg;
	logic fclk_d_reg;
	logic gclk_d_reg;
	logic pclk_d_reg;
	logic mclk_rise;
	logic bclk_rise;
	logic fclk_rise;
	logic pclk_rise;

	// Run-in tracking
	logic [31:0] act_cnt_reg [3]; // Cycles since last edge of master, bit, frame
	logic [31:0] ready_cnt_reg;   // Cycles with all three clocks alive
	logic        all_alive;

	// Ratio measurement
	logic [11:0] mclk_cnt_reg;    // Master edges within current frame
	logic [15:0] frame_cyc_reg;   // Core cycles within current frame
	logic        low_rate_reg;    // Frame rate at or below the 64 kHz split

	// Coefficient arithmetic
	logic [19:0] k_scaled;        // J.D times ten thousand
	logic [4:0]  r_val;           // R as a number
	logic        wr_ok;

	// Divider carriers
	div_if #(.W(PROC_W))     proc_if ();
	div_if #(.W(BIT_W))      bit_if ();
	div_if #(.W(FRAME_W))    frame_if ();
	div_if #(.W(SAMPLE_N_W)) sample_if ();

	// Accepts a master clock ratio for the present PLL mode
	function automatic logic ratio_supported(input logic [11:0] ratio,
	                                         input logic        pll_on,
	                                         input logic        low_rate);
		logic ok;
		ok = 1'b0;
		unique case (ratio)
			RATIO_64:  ok = 1'b0;
			RATIO_128: ok = pll_on;
			RATIO_192: ok = pll_on && low_rate;
			RATIO_256: ok = 1'b1;
			RATIO_384: ok = 1'b1;
			RATIO_512: ok = 1'b1;
			default:   ok = 1'b0;
		endcase
		return ok;
	endfunction : ratio_supported

	// Edge pulses from the previous sample of the master, bit, frame and PLL output pins
	always_comb begin
		mclk_rise = master_clk_in && !mclk_d_reg;
		bclk_rise = bit_clk_in && !bclk_d_reg;
		fclk_rise = frame_sync_clock && !fclk_d_reg;
		pclk_rise = pll_output_clock && !pclk_d_reg;
	end

	// Pin history
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mclk_d_reg <= 1'b0;
			bclk_d_reg <= 1'b0;
			fclk_d_reg <= 1'b0;
			gclk_d_reg <= 1'b0;
			pclk_d_reg <= 1'b0;
		end else begin
			mclk_d_reg <= master_clk_in;
			bclk_d_reg <= bit_clk_in;
			fclk_d_reg <= frame_sync_clock;
			gclk_d_reg <= gpio_clk_in;
			pclk_d_reg <= pll_output_clock;
		end
	end

	// Liveness of the master, bit and frame clocks; a stuck clock restarts the run-in
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 3; i++) begin
				act_cnt_reg[i] <= 32'h0000_0000;
			end
		end else begin
			act_cnt_reg[0] <= mclk_rise ? 32'h0 : act_cnt_reg[0] + 32'(act_cnt_reg[0] < 32'(ACT_CYCLES));
			act_cnt_reg[1] <= bclk_rise ? 32'h0 : act_cnt_reg[1] + 32'(act_cnt_reg[1] < 32'(ACT_CYCLES));
			act_cnt_reg[2] <= fclk_rise ? 32'h0 : act_cnt_reg[2] + 32'(act_cnt_reg[2] < 32'(ACT_CYCLES));
		end
	end

	always_comb begin
		all_alive = (act_cnt_reg[0] < 32'(ACT_CYCLES)) && (act_cnt_reg[1] < 32'(ACT_CYCLES))
		         && (act_cnt_reg[2] < 32'(ACT_CYCLES));
	end

	// Register file stays locked until the clocks have run long enough; once open it stays open
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ready_cnt_reg <= 32'h0000_0000;
			reg_ready     <= 1'b0;
		end else if (!reg_ready) begin
			if (!all_alive) begin
				ready_cnt_reg <= 32'h0000_0000;
			end else if (ready_cnt_reg >= 32'(READY_CYCLES - 1)) begin
				reg_ready <= 1'b1;
			end else begin
				ready_cnt_reg <= ready_cnt_reg + 32'h1;
			end
		end
	end

	assign wr_ok = reg_wr && reg_ready;

	// Register writes; unused bits are dropped, unmapped offsets ignored
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pll_on_bit               <= PLL_ON_RST;
			pll_ref_source_field_reg <= REF_RST;
			pll_p_field_reg          <= P_RST;
			pll_j_field_reg          <= J_RST;
			pll_d_field_reg          <= D_RST;
			pll_r_field_reg          <= R_RST;
			processing_clock_div_reg <= PROC_W'(DIV_RST);
			bit_clock_out_div_reg    <= BIT_W'(DIV_RST);
			frame_clock_out_div_reg  <= FRAME_W'(DIV_RST);
		end else if (wr_ok) begin
			unique case (reg_addr)
				PLL_ON_OFF:    pll_on_bit <= reg_wdata[0];
				REF_SEL_OFF:   pll_ref_source_field_reg <= reg_wdata[REF_LSB +: REF_W];
				P_OFF:         pll_p_field_reg <= reg_wdata[P_W-1:0];
				J_OFF:         pll_j_field_reg <= reg_wdata[J_W-1:0];
				D_HIGH_OFF:    pll_d_field_reg[D_W-1:8] <= reg_wdata[D_HIGH_W-1:0];
				D_LOW_OFF:     pll_d_field_reg[7:0] <= reg_wdata;
				R_OFF:         pll_r_field_reg <= reg_wdata[R_W-1:0];
				PROC_DIV_OFF:  processing_clock_div_reg <= reg_wdata[PROC_W-1:0];
				BIT_DIV_OFF:   bit_clock_out_div_reg <= reg_wdata[BIT_W-1:0];
				FRAME_DIV_OFF: frame_clock_out_div_reg <= reg_wdata;
				default:       ;
			endcase
		end
	end

	// Read data, registered one cycle after the read strobe; reserved bits read zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				PLL_ON_OFF:    reg_rdata <= {7'h00, pll_on_bit};
				REF_SEL_OFF:   reg_rdata <= {1'b0, pll_ref_source_field_reg, 4'h0};
				P_OFF:         reg_rdata <= {4'h0, pll_p_field_reg};
				J_OFF:         reg_rdata <= {2'h0, pll_j_field_reg};
				D_HIGH_OFF:    reg_rdata <= {2'h0, pll_d_field_reg[D_W-1:8]};
				D_LOW_OFF:     reg_rdata <= pll_d_field_reg[7:0];
				R_OFF:         reg_rdata <= {4'h0, pll_r_field_reg};
				PROC_DIV_OFF:  reg_rdata <= {1'b0, processing_clock_div_reg};
				BIT_DIV_OFF:   reg_rdata <= {1'b0, bit_clock_out_div_reg};
				FRAME_DIV_OFF: reg_rdata <= frame_clock_out_div_reg;
				default:       reg_rdata <= 8'h00;
			endcase
		end
	end

	// Reference mux; the selected level feeds the PLL input
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pll_input_clock <= 1'b0;
		end else begin
			unique case (pll_ref_source_field_reg)
				REF_BIT:  pll_input_clock <= bclk_d_reg;
				REF_GPIO: pll_input_clock <= gclk_d_reg;
				default:  pll_input_clock <= mclk_d_reg;
			endcase
		end
	end

	// Coefficients: K kept as J times ten thousand plus D, so no fraction is lost
	always_comb begin
		k_scaled = 20'(pll_j_field_reg) * 20'(DEC_SCALE) + 20'(pll_d_field_reg);
		r_val    = 5'(pll_r_field_reg) + 5'h01;
	end

	// Multiplier and pre-divider presented to the PLL macro
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pll_mult    <= 24'h000000;
			pll_pre_div <= 5'h01;
		end else begin
			pll_mult    <= 24'(r_val) * 24'(k_scaled);
			pll_pre_div <= 5'(pll_p_field_reg) + 5'h01;
		end
	end

	// Out-of-range coefficients; the input and output frequency windows stay with software
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pll_cfg_error <= 1'b0;
		end else begin
			pll_cfg_error <= pll_on_bit && ((pll_j_field_reg < J_W'(J_MIN))
			              || (pll_d_field_reg > D_W'(D_MAX))
			              || ((pll_d_field_reg != '0) && ((pll_j_field_reg > J_W'(J_FRAC_MAX))
			              || (pll_r_field_reg != '0))));
		end
	end

	// Master edges and core cycles per frame, latched at each frame edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mclk_cnt_reg  <= 12'h000;
			frame_cyc_reg <= 16'h0000;
			mclk_ratio    <= 12'h000;
			low_rate_reg  <= 1'b0;
		end else if (fclk_rise) begin
			mclk_ratio    <= mclk_cnt_reg + 12'(mclk_rise);
			low_rate_reg  <= frame_cyc_reg >= 16'(FS_SPLIT_CYC);
			mclk_cnt_reg  <= 12'h000;
			frame_cyc_reg <= 16'h0000;
		end else begin
			if (mclk_rise && mclk_cnt_reg != 12'hfff) begin
				mclk_cnt_reg <= mclk_cnt_reg + 12'h001;
			end
			if (frame_cyc_reg != 16'hffff) begin
				frame_cyc_reg <= frame_cyc_reg + 16'h0001;
			end
		end
	end

	// Ratio check follows the PLL mode so a bypass change re-judges at once
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_ratio_error <= 1'b0;
		end else begin
			clk_ratio_error <= !ratio_supported(mclk_ratio, pll_on_bit, low_rate_reg);
		end
	end

	// Divider sources: processing clock runs from the PLL or, bypassed, the master clock
	always_comb begin
		proc_if.tick_in   = pll_on_bit ? pclk_rise : mclk_rise;
		proc_if.ratio     = processing_clock_div_reg;
		bit_if.tick_in    = mclk_rise;
		bit_if.ratio      = bit_clock_out_div_reg;
		frame_if.tick_in  = bit_if.tick_out;
		frame_if.ratio    = frame_clock_out_div_reg;
		sample_if.tick_in = pll_on_bit && pclk_rise;
		sample_if.ratio   = SAMPLE_RATIO;
	end

	clk_div #(.W(PROC_W)) u_proc_div (
		.clk   (clk),
		.rst_b (rst_b),
		.d     (proc_if.div)
	);

	clk_div #(.W(BIT_W)) u_bit_div (
		.clk   (clk),
		.rst_b (rst_b),
		.d     (bit_if.div)
	);

	clk_div #(.W(FRAME_W)) u_frame_div (
		.clk   (clk),
		.rst_b (rst_b),
		.d     (frame_if.div)
	);

	clk_div #(.W(SAMPLE_N_W)) u_sample_div (
		.clk   (clk),
		.rst_b (rst_b),
		.d     (sample_if.div)
	);

	// Divider outputs are flops inside the dividers; presented directly
	assign proc_clk_tick = proc_if.tick_out;
	assign proc_clk      = proc_if.level_out;
	assign bit_clk_out   = bit_if.level_out;
	assign frame_clk_out = frame_if.level_out;
	assign sample_tick   = sample_if.tick_out;

endmodule : audio_pll_clock_generation

// File: sim/audio_pll_clock_generation_assertions.sv
// Purpose: Port-level checks of the PLL clock configuration block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Registered errors are given two cycles
`timescale 1ns/10ps
module pll_clock_checker
	import pll_clk_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_ready,
	input wire logic        pll_on_bit,
	input wire logic [4:0]  pll_pre_div,
	input wire logic        pll_cfg_error,
	input wire logic        sample_tick,
	input wire logic [11:0] mclk_ratio,
	input wire logic        clk_ratio_error
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// Written P must reach the pre-divider output as field plus one
	property p_pre_div;
		logic [3:0] v;
		(reg_wr && reg_ready && reg_addr == P_OFF, v = reg_wdata[3:0])
			|-> ##2 pll_pre_div == {1'b0, v} + 5'h01;
	endproperty

	reset_defaults_a: assert property ($rose(rst_b) |-> pll_on_bit && pll_pre_div == 5'h01)
		else $error("reset defaults wrong");
	early_write_a: assert property (reg_wr && !reg_ready && reg_addr == PLL_ON_OFF
		|=> $stable(pll_on_bit)) else $error("write taken before ready");
	enable_write_a: assert property (reg_wr && reg_ready && reg_addr == PLL_ON_OFF
		|=> pll_on_bit == $past(reg_wdata[0])) else $error("enable write lost");
	pre_div_a: assert property (p_pre_div) else $error("pre divider wrong");
	unmapped_read_a: assert property (reg_rd && reg_addr == 8'hff |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	ready_sticky_a: assert property (reg_ready |=> reg_ready) else $error("ready dropped");
	ratio_64_a: assert property ((mclk_ratio == RATIO_64) [*3] |-> clk_ratio_error)
		else $error("ratio 64 accepted");
	ratio_256_a: assert property ((mclk_ratio == RATIO_256) [*3] |-> !clk_ratio_error)
		else $error("ratio 256 refused");
	sample_off_a: assert property ((!pll_on_bit) [*3] |-> !sample_tick)
		else $error("sample tick with pll off");
	cfg_off_a: assert property ((!pll_on_bit) [*3] |-> !pll_cfg_error)
		else $error("coefficient error with pll off");

	// Main scenarios reached
	cover property ($rose(reg_ready));
	cover property (sample_tick);
	cover property (clk_ratio_error && mclk_ratio == RATIO_192);
endmodule : pll_clock_checker

bind audio_pll_clock_generation pll_clock_checker chk (.clk, .rst_b, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .reg_ready, .pll_on_bit, .pll_pre_div, .pll_cfg_error,
	.sample_tick, .mclk_ratio, .clk_ratio_error);

// File: sim/audio_host_model.sv
// Purpose: Serial audio host driving master, bit and frame clocks
// Assumes: Clocks are made synchronously from the core clock
// Notes:   Frame period counts master rises, so the ratio is exact
`timescale 1ns/10ps
module audio_host_model (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [3:0]  half,
	input  wire logic [11:0] ratio,
	output logic             master_clk,
	output logic             bit_clk,
	output logic             frame_clk
);
	logic [3:0]  ph_reg; // Cycles into the master half period
	logic [11:0] fr_reg; // Master rises into the frame
	logic        bc_reg; // Alternates on master rises

	// Half period of two or more cycles keeps master at or under 31.25 MHz
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ph_reg     <= 4'h0;
			fr_reg     <= 12'h000;
			bc_reg     <= 1'b0;
			master_clk <= 1'b0;
			bit_clk    <= 1'b0;
			frame_clk  <= 1'b0;
		end else if (ph_reg + 4'h1 < half) begin
			ph_reg <= ph_reg + 4'h1;
		end else begin
			ph_reg     <= 4'h0;
			master_clk <= !master_clk;
			// Bit and frame clocks move only on a master rise
			if (!master_clk) begin
				bc_reg    <= !bc_reg;
				bit_clk   <= bc_reg ? !bit_clk : bit_clk;
				fr_reg    <= (fr_reg + 12'h001 >= ratio) ? 12'h000 : fr_reg + 12'h001;
				frame_clk <= fr_reg < {1'b0, ratio[11:1]};
			end
		end
	end
endmodule : audio_host_model

// File: sim/audio_pll_clock_generation_tb.sv
// Purpose: Self-checking bench for the PLL clock configuration block
// Assumes: Run-in shortened to 50 cycles by parameter
// Notes:   PLL output toggles every cycle; GPIO clock every 32 cycles
`timescale 1ns/10ps
module audio_pll_clock_generation_tb;
	import pll_clk_pkg::*;
	localparam logic [7:0] OFFS [10] = '{PLL_ON_OFF, REF_SEL_OFF, P_OFF, J_OFF, D_HIGH_OFF,
		D_LOW_OFF, R_OFF, PROC_DIV_OFF, BIT_DIV_OFF, FRAME_DIV_OFF};
	localparam logic [7:0] MASKS [10] = '{8'h01, 8'h70, 8'h0f, 8'h3f, 8'h3f, 8'hff, 8'h0f,
		8'h7f, 8'h7f, 8'hff};
	localparam logic [2:0] CODES [4] = '{REF_MASTER, REF_BIT, REF_GPIO, 3'h2};
	localparam int         LO [4]    = '{15, 3, 0, 15}; // Rises in 64 cycles
	localparam int         HI [4]    = '{17, 5, 2, 17};
	localparam logic [11:0] RTAB [9] = '{RATIO_256, RATIO_64, RATIO_128, RATIO_128, RATIO_192,
		12'h064, RATIO_384, RATIO_512, RATIO_192};
	localparam logic [8:0] ONV = 9'b1_1111_0111; // PLL on per ratio case
	localparam logic [8:0] ERV = 9'b0_0011_1010; // Expected error per case
	logic        clk, rst_b, mclk, bclk, fclk, gpio_clk_in, pll_output_clock, reg_wr, reg_rd;
	logic        reg_ready, pll_on_bit, pll_input_clock, pll_cfg_error, proc_clk_tick, proc_clk;
	logic        bit_clk_out, frame_clk_out, sample_tick, clk_ratio_error;
	logic [4:0]  gcnt, pll_pre_div;
	logic [3:0]  half;
	logic [11:0] ratio, mclk_ratio;
	logic [7:0]  reg_addr, reg_wdata, rdat, reg_rdata;
	logic [23:0] pll_mult;
	int          failures = 0, checked = 0;
	wire  [5:0]  mon = {proc_clk, sample_tick, proc_clk_tick, frame_clk_out, bit_clk_out,
		pll_input_clock};

	audio_host_model host (.clk, .rst_b, .half, .ratio, .master_clk(mclk), .bit_clk(bclk),
		.frame_clk(fclk));
	audio_pll_clock_generation #(.READY_CYCLES(50), .ACT_CYCLES(8192)) uut (
		.clk, .rst_b, .master_clk_in(mclk), .bit_clk_in(bclk), .frame_sync_clock(fclk),
		.gpio_clk_in, .pll_output_clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.reg_ready, .pll_on_bit, .pll_input_clock, .pll_pre_div, .pll_mult, .pll_cfg_error,
		.proc_clk_tick, .proc_clk, .bit_clk_out, .frame_clk_out, .sample_tick, .mclk_ratio,
		.clk_ratio_error);

	initial begin
		clk = 1'b0;
		forever #4 clk = !clk;
	end

	// Stand-ins for the analog PLL output and a GPIO clock
	always @(posedge clk) begin
		pll_output_clock <= !pll_output_clock;
		gcnt             <= gcnt + 5'h01;
		if (gcnt == 5'h1f) begin
			gpio_clk_in <= !gpio_clk_in;
		end
	end

	task check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	task report_and_stop;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	// Trailing edge parts back-to-back calls; returns with outputs settled
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
		#1;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		#1 d = reg_rdata;
	endtask : rd

	// Rising edges of one monitored output over n cycles
	task count(input int s, input int n, output int c);
		logic p;
		p = 1'b1;
		c = 0;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (mon[s] && !p) c++;
			p = mon[s];
		end
	endtask : count

	task set_k(input logic [5:0] j, input logic [13:0] d, input logic [3:0] r);
		wr(J_OFF, {2'b00, j});
		wr(D_HIGH_OFF, {2'b00, d[13:8]});
		wr(D_LOW_OFF, d[7:0]);
		wr(R_OFF, {4'h0, r});
		repeat (3) @(posedge clk);
		#1;
	endtask : set_k

	// Early enable write is dropped; registers at defaults
	task t_reset;
		wr(PLL_ON_OFF, 8'h00);
		check(pll_mult, 24'h013880, "reset mult");
		for (int i = 0; i < 10; i++) begin
			rd(OFFS[i], rdat);
			check(24'(rdat), i == 0 ? 24'h1 : i == 3 ? 24'h8 : 24'h0, "reset value");
		end
		check(24'(reg_ready), 24'h0, "ready early");
	endtask : t_reset

	task t_ready;
		int n;
		for (n = 0; n < 5000 && reg_ready !== 1'b1; n++) @(posedge clk);
		check(24'(reg_ready), 24'h1, "ready");
		if (n == 5000) report_and_stop();
	endtask : t_ready

	// All ones then all zeros; reserved bits read back zero
	task t_regs;
		logic [7:0] d;
		for (int p = 0; p < 2; p++) begin
			d = p == 0 ? 8'hff : 8'h00;
			for (int i = 0; i < 10; i++) begin
				wr(OFFS[i], d);
				rd(OFFS[i], rdat);
				check(24'(rdat), 24'(d & MASKS[i]), "register");
			end
		end
		wr(8'hff, 8'h55);
		rd(8'hff, rdat);
		check(24'(rdat), 24'h0, "unmapped");
	endtask : t_regs

	task t_coef;
		wr(PLL_ON_OFF, 8'h01);
		wr(P_OFF, 8'h01);
		set_k(6'd10, 14'd1920, 4'h0);
		check(pll_mult, 24'h018e20, "mult fraction");
		check(24'(pll_pre_div), 24'h2, "pre div");
		check(24'(pll_cfg_error), 24'h0, "legal fraction");
		set_k(6'd10, 14'd1920, 4'h1);
		check(pll_mult, 24'h031c40, "mult r2");
		check(24'(pll_cfg_error), 24'h1, "fraction r2");
		set_k(6'd12, 14'd1920, 4'h0);
		check(24'(pll_cfg_error), 24'h1, "fraction j12");
		set_k(6'd3, 14'd1, 4'h0);
		check(24'(pll_cfg_error), 24'h1, "j3");
		set_k(6'd10, 14'd10000, 4'h0);
		check(24'(pll_cfg_error), 24'h1, "d10000");
		wr(PLL_ON_OFF, 8'h00);
		check(24'(pll_cfg_error), 24'h0, "error off");
		wr(PLL_ON_OFF, 8'h01);
		wr(P_OFF, 8'h0f);
		set_k(6'd8, 14'd0, 4'hf);
		check(pll_mult, 24'h138800, "mult r16");
		check(24'(pll_pre_div), 24'h10, "pre div 16");
		check(24'(pll_cfg_error), 24'h0, "legal integer");
	endtask : t_coef

	task t_ref;
		int c;
		for (int i = 0; i < 4; i++) begin
			wr(REF_SEL_OFF, {1'b0, CODES[i], 4'h0});
			count(0, 64, c);
			check(24'(c >= LO[i] && c <= HI[i]), 24'h1, "reference");
		end
	endtask : t_ref

	// Master rises 64 and PLL rises 128 per 256 cycles
	task t_div;
		int c;
		wr(PROC_DIV_OFF, 8'h07);
		wr(BIT_DIV_OFF, 8'h03);
		wr(FRAME_DIV_OFF, 8'h01);
		count(3, 256, c);
		check(24'(c >= 15 && c <= 17), 24'h1, "proc from pll");
		count(1, 256, c);
		check(24'(c >= 15 && c <= 17), 24'h1, "bit div");
		count(2, 256, c);
		check(24'(c >= 7 && c <= 9), 24'h1, "frame div");
		wr(PLL_ON_OFF, 8'h00);
		count(5, 256, c);
		check(24'(c >= 7 && c <= 9), 24'h1, "proc from master");
		wr(PLL_ON_OFF, 8'h01);
		wr(PROC_DIV_OFF, 8'h00);
		count(3, 256, c);
		check(24'(c >= 127 && c <= 129), 24'h1, "proc div one");
	endtask : t_div

	task t_sample;
		int c;
		count(4, 8300, c);
		check(24'(c >= 2 && c <= 3), 24'h1, "sample on");
		wr(PLL_ON_OFF, 8'h00);
		count(4, 8300, c);
		check(24'(c), 24'h0, "sample off");
	endtask : t_sample

	// Three frame periods let the measured ratio settle
	task t_ratio;
		for (int i = 0; i < 9; i++) begin
			wr(PLL_ON_OFF, {7'h00, ONV[i]});
			ratio <= RTAB[i];
			half  <= i == 8 ? 4'h6 : 4'h2;
			repeat (RTAB[i] * (i == 8 ? 36 : 12) + 50) @(posedge clk);
			#1;
			check(24'(mclk_ratio), 24'(RTAB[i]), "ratio");
			check(24'(clk_ratio_error), 24'(ERV[i]), "ratio error");
		end
	endtask : t_ratio

	initial begin
		rst_b = 1'b0;
		gpio_clk_in = 1'b0;
		pll_output_clock = 1'b0;
		gcnt = 5'h00;
		half = 4'h2;
		ratio = RATIO_256;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_ready();
		t_regs();
		t_coef();
		t_ref();
		t_div();
		t_sample();
		t_ratio();
		report_and_stop();
	end
endmodule : audio_pll_clock_generation_tb
